//--- design/cfe_pkg.sv
// shared constants and types of the fetch/execute core
package cfe_pkg;

   localparam int          CFE_RF_ENTRIES = 32;
   localparam int          CFE_RF_AW      = 5;
   localparam int          CFE_PW         = 16;
   localparam int          CFE_DW         = 8;
   localparam logic [7:0]  CFE_IO_BASE    = 8'h20;
   localparam logic [15:0] CFE_PC_RESET   = 16'h0000;
   localparam logic [7:0]  CFE_SREG_RESET = 8'h00;

   // status bit positions
   localparam int CFE_F_T = 6;
   localparam int CFE_F_H = 5;
   localparam int CFE_F_S = 4;
   localparam int CFE_F_V = 3;
   localparam int CFE_F_N = 2;
   localparam int CFE_F_Z = 1;
   localparam int CFE_F_C = 0;

   // pointer pair low-byte indices
   localparam logic [4:0] CFE_PTR_X = 5'h1a;
   localparam logic [4:0] CFE_PTR_Y = 5'h1c;
   localparam logic [4:0] CFE_PTR_Z = 5'h1e;

   typedef enum logic [3:0] {
      CFE_ALU_ADD = 4'h0,
      CFE_ALU_ADC = 4'h1,
      CFE_ALU_SUB = 4'h2,
      CFE_ALU_SBC = 4'h3,
      CFE_ALU_AND = 4'h4,
      CFE_ALU_OR  = 4'h5,
      CFE_ALU_EOR = 4'h6,
      CFE_ALU_MOV = 4'h7
   } cfe_alu_op_t;

   typedef enum logic [3:0] {
      CFE_ST_RUN  = 4'b0001,
      CFE_ST_LOAD = 4'b0010,
      CFE_ST_BIT  = 4'b0100,
      CFE_ST_LPM  = 4'b1000
   } cfe_state_t;

endpackage : cfe_pkg

//--- design/cfe_alu.sv
// arithmetic and logic unit with status flag generation
`timescale 1ns/1ps
module cfe_alu
   import cfe_pkg::*;
(
   input  wire cfe_alu_op_t op_in,
   input  wire logic [7:0]  a_in,
   input  wire logic [7:0]  b_in,
   input  wire logic [7:0]  sreg_in,
   output logic      [7:0]  res_out,
   output logic      [7:0]  sreg_out
);

   logic [8:0] sum;
   logic [7:0] r;
   logic       cin;

   always_comb
   begin
      sum      = 9'h000;
      r        = 8'h00;
      cin      = sreg_in[CFE_F_C];
      sreg_out = sreg_in;
      unique case (op_in)
         CFE_ALU_ADD, CFE_ALU_ADC:
         begin
            sum = {1'b0, a_in} + {1'b0, b_in} + {8'h00, (op_in == CFE_ALU_ADC) & cin};
            r   = sum[7:0];
            sreg_out[CFE_F_C] = sum[8];
            sreg_out[CFE_F_H] = (a_in[3] & b_in[3]) | (b_in[3] & ~r[3]) | (~r[3] & a_in[3]);
            sreg_out[CFE_F_V] = (a_in[7] & b_in[7] & ~r[7]) | (~a_in[7] & ~b_in[7] & r[7]);
         end
         CFE_ALU_SUB, CFE_ALU_SBC:
         begin
            sum = {1'b0, a_in} - {1'b0, b_in} - {8'h00, (op_in == CFE_ALU_SBC) & cin};
            r   = sum[7:0];
            sreg_out[CFE_F_C] = (~a_in[7] & b_in[7]) | (b_in[7] & r[7]) | (r[7] & ~a_in[7]);
            sreg_out[CFE_F_H] = (~a_in[3] & b_in[3]) | (b_in[3] & r[3]) | (r[3] & ~a_in[3]);
            sreg_out[CFE_F_V] = (a_in[7] & ~b_in[7] & ~r[7]) | (~a_in[7] & b_in[7] & r[7]);
         end
         CFE_ALU_AND: r = a_in & b_in;
         CFE_ALU_OR:  r = a_in | b_in;
         CFE_ALU_EOR: r = a_in ^ b_in;
         CFE_ALU_MOV: r = b_in;
      endcase
      if (op_in inside {CFE_ALU_AND, CFE_ALU_OR, CFE_ALU_EOR})
         sreg_out[CFE_F_V] = 1'b0;
      if (op_in != CFE_ALU_MOV)
      begin
         // borrow chain keeps zero only if it was already zero
         sreg_out[CFE_F_Z] = (r == 8'h00) & ((op_in != CFE_ALU_SBC) | sreg_in[CFE_F_Z]);
         sreg_out[CFE_F_N] = r[7];
         sreg_out[CFE_F_S] = r[7] ^ sreg_out[CFE_F_V];
      end
      res_out = r;
   end

endmodule : cfe_alu

//--- design/cfe_core.sv
// fetch/execute core: pipeline, register file, pointer and memory buses
`timescale 1ns/1ps

// Notes on behaviour
// - program fetch and data access use separate buses working independently
// - single-level pipeline: one fetch stage overlaps one execute stage
// - next word is fetched while current executes, single-word register ops complete one per clock
// - thirty-two 8-bit working registers, each reachable within one clock
// - two operands read, computed and written back in one clock
// - three register pairs act as 16-bit indirect data pointers
// - the last pointer pair also addresses table reads from program memory
// - short port and port-bit instructions never reach the extended I/O region
// - status flags updated after every arithmetic or logic operation
// - fetch handles both one-word and two-word instructions
module cfe_core
   import cfe_pkg::*;
#(
   parameter int RS_DEPTH = 4
)
(
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   output logic      [15:0] pm_addr_out,
   input  wire logic [15:0] pm_data_in,
   output logic      [15:0] dm_addr_out,
   output logic      [7:0]  dm_wdata_out,
   output logic             dm_we_out,
   output logic             dm_re_out,
   input  wire logic [7:0]  dm_rdata_in,
   output logic      [7:0]  sreg_out
);

   localparam int RSW = $clog2(RS_DEPTH);

   typedef struct packed {
      logic [CFE_RF_ENTRIES-1:0][7:0] rf;
      logic [15:0]                    pc;
      logic [15:0]                    ir;
      logic                           ir_v;
      logic [7:0]                     sreg;
      cfe_state_t                     st;
      logic [4:0]                     rd;
      logic [2:0]                     bsel;
      logic [1:0]                     bop;
      logic [15:0]                    lpm_a;
      logic [15:0]                    dm_addr;
      logic [7:0]                     dm_wdata;
      logic                           dm_we;
      logic                           dm_re;
      logic [RS_DEPTH-1:0][15:0]      rstk;
      logic [RSW-1:0]                 rsp;
   } cfe_core_state_t;

   cfe_core_state_t s_q, s_d;

   cfe_alu_op_t alu_op;
   logic [7:0]  alu_a, alu_b, alu_res, alu_sreg;
   logic [15:0] ir;
   logic [4:0]  rd_r, rd_i, rr_r;
   logic [7:0]  kimm, iobit;

   function automatic logic [15:0] ptr_val(input logic [CFE_RF_ENTRIES-1:0][7:0] rf, input logic [4:0] lo);
      ptr_val = {rf[lo + 5'h01], rf[lo]};
   endfunction : ptr_val

   function automatic logic [15:0] io_addr(input logic [5:0] a);
      io_addr = {8'h00, CFE_IO_BASE + {2'b00, a}};
   endfunction : io_addr

   assign ir   = s_q.ir;
   assign rd_r = ir[8:4];
   assign rr_r = {ir[9], ir[3:0]};
   assign rd_i = {1'b1, ir[7:4]};
   assign kimm = {ir[11:8], ir[3:0]};

   // one ALU serves add/sub/logic ops from two register-file read ports, or from one register and an immediate
   cfe_alu u_alu (
      .op_in    (alu_op),
      .a_in     (alu_a),
      .b_in     (alu_b),
      .sreg_in  (s_q.sreg),
      .res_out  (alu_res),
      .sreg_out (alu_sreg)
   );

   always_comb
   begin
      s_d      = s_q;
      alu_op   = CFE_ALU_MOV;
      alu_a    = s_q.rf[rd_r];
      alu_b    = s_q.rf[rr_r];
      iobit    = 8'h00;
      s_d.dm_we = 1'b0;
      s_d.dm_re = 1'b0;
      unique case (s_q.st)
         CFE_ST_RUN:
         begin
            // prefetch runs every cycle in this state
            s_d.ir   = pm_data_in;
            s_d.ir_v = 1'b1;
            s_d.pc   = s_q.pc + 16'h0001;
            if (s_q.ir_v)
            begin
               casez (ir)
                  16'b000?11??_????_????, 16'b0001_10??_????_????, 16'b0000_10??_????_????,
                  16'b0001_01??_????_????, 16'b0010_????_????_????:
                  begin
                     unique casez (ir[13:10])
                        4'b0011: alu_op = CFE_ALU_ADD;
                        4'b0111: alu_op = CFE_ALU_ADC;
                        4'b0110, 4'b0101: alu_op = CFE_ALU_SUB;
                        4'b0010: alu_op = CFE_ALU_SBC;
                        4'b1000: alu_op = CFE_ALU_AND;
                        4'b1001: alu_op = CFE_ALU_EOR;
                        4'b1010: alu_op = CFE_ALU_OR;
                        default: alu_op = CFE_ALU_MOV;
                     endcase
                     if (ir[13:10] != 4'b0101)
                        s_d.rf[rd_r] = alu_res;
                     s_d.sreg = alu_sreg;
                  end
                  16'b0011_????_????_????, 16'b0101_????_????_????, 16'b0111_????_????_????,
                  16'b0110_????_????_????, 16'b1110_????_????_????:
                  begin
                     alu_a = s_q.rf[rd_i];
                     alu_b = kimm;
                     unique case (ir[15:12])
                        4'h3, 4'h5: alu_op = CFE_ALU_SUB;
                        4'h7: alu_op = CFE_ALU_AND;
                        4'h6: alu_op = CFE_ALU_OR;
                        default: alu_op = CFE_ALU_MOV;
                     endcase
                     if (ir[15:12] != 4'h3)
                        s_d.rf[rd_i] = alu_res;
                     s_d.sreg = alu_sreg;
                  end
                  16'b1100_????_????_????, 16'b1101_????_????_????:
                  begin
                     if (ir[12])
                     begin
                        s_d.rstk[s_q.rsp] = s_q.pc;
                        s_d.rsp = s_q.rsp + 1'b1;
                     end
                     s_d.pc   = s_q.pc + {{4{ir[11]}}, ir[11:0]};
                     s_d.ir_v = 1'b0;
                  end
                  16'b1111_0???_????_????:
                     if (s_q.sreg[ir[2:0]] != ir[10])
                     begin
                        s_d.pc   = s_q.pc + {{9{ir[9]}}, ir[9:3]};
                        s_d.ir_v = 1'b0;
                     end
                  16'h9508:
                  begin
                     s_d.rsp  = s_q.rsp - 1'b1;
                     s_d.pc   = s_q.rstk[s_q.rsp - 1'b1];
                     s_d.ir_v = 1'b0;
                  end
                  16'b1001_010?_????11??:
                  begin
                     // second word is on the fetch bus this cycle
                     if (ir[1])
                     begin
                        s_d.rstk[s_q.rsp] = s_q.pc + 16'h0001;
                        s_d.rsp = s_q.rsp + 1'b1;
                     end
                     s_d.pc   = pm_data_in;
                     s_d.ir_v = 1'b0;
                  end
                  16'b1001_00??_????0000:
                  begin
                     s_d.ir_v    = 1'b0;
                     s_d.dm_addr = pm_data_in;
                     s_d.rd      = rd_r;
                     if (ir[9])
                     begin
                        s_d.dm_wdata = s_q.rf[rd_r];
                        s_d.dm_we    = 1'b1;
                     end
                     else
                     begin
                        s_d.dm_re = 1'b1;
                        s_d.st    = CFE_ST_LOAD;
                     end
                  end
                  16'b1001_00??_????1100, 16'b1000_00??_????1000, 16'b1000_00??_????0000:
                  begin
                     s_d.dm_addr = ptr_val(s_q.rf, ir[12] ? CFE_PTR_X :
                                           (ir[3] ? CFE_PTR_Y : CFE_PTR_Z));
                     s_d.rd      = rd_r;
                     if (ir[9])
                     begin
                        s_d.dm_wdata = s_q.rf[rd_r];
                        s_d.dm_we    = 1'b1;
                     end
                     else
                     begin
                        s_d.dm_re = 1'b1;
                        s_d.st    = CFE_ST_LOAD;
                     end
                  end
                  16'b1001_000?_????0100:
                  begin
                     s_d.lpm_a = ptr_val(s_q.rf, CFE_PTR_Z);
                     s_d.rd    = rd_r;
                     s_d.st    = CFE_ST_LPM;
                  end
                  16'b1011_????_????_????:
                  begin
                     s_d.dm_addr = io_addr({ir[10:9], ir[3:0]});
                     s_d.rd      = rd_r;
                     if (ir[11])
                     begin
                        s_d.dm_wdata = s_q.rf[rd_r];
                        s_d.dm_we    = 1'b1;
                     end
                     else
                     begin
                        s_d.dm_re = 1'b1;
                        s_d.st    = CFE_ST_LOAD;
                     end
                  end
                  16'b1001_10??_????_????:
                  begin
                     s_d.dm_addr = io_addr({1'b0, ir[7:3]});
                     s_d.bsel    = ir[2:0];
                     s_d.bop     = ir[9:8];
                     s_d.dm_re   = 1'b1;
                     s_d.st      = CFE_ST_BIT;
                  end
                  default: ;
               endcase
            end
         end
         CFE_ST_LOAD:
         begin
            s_d.rf[s_q.rd] = dm_rdata_in;
            s_d.st         = CFE_ST_RUN;
         end
         CFE_ST_BIT:
         begin
            iobit = 8'h01 << s_q.bsel;
            s_d.st = CFE_ST_RUN;
            unique case (s_q.bop)
               2'b00, 2'b10:
               begin
                  // port_bit_clear_op / port_bit_set_op: write back the modified byte
                  s_d.dm_wdata = s_q.bop[1] ? (dm_rdata_in | iobit) : (dm_rdata_in & ~iobit);
                  s_d.dm_we    = 1'b1;
               end
               default:
                  // skip_if_port_bit_clear_op / skip_if_port_bit_set_op
                  if (((dm_rdata_in & iobit) != 8'h00) == s_q.bop[1])
                     s_d.ir_v = 1'b0;
            endcase
         end
         CFE_ST_LPM:
         begin
            s_d.rf[s_q.rd] = s_q.lpm_a[0] ? pm_data_in[15:8] : pm_data_in[7:0];
            s_d.st         = CFE_ST_RUN;
         end
      endcase
   end

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         s_q      <= '0;
         s_q.pc   <= CFE_PC_RESET;
         s_q.sreg <= CFE_SREG_RESET;
         s_q.st   <= CFE_ST_RUN;
      end
      else
         s_q <= s_d;
   end

   // fetch bus and data bus driven independently
   // table pointer is a byte address: word = pointer / 2
   assign pm_addr_out  = (s_q.st == CFE_ST_LPM) ? {1'b0, s_q.lpm_a[15:1]} : s_q.pc;
   assign dm_addr_out  = s_q.dm_addr;
   assign dm_wdata_out = s_q.dm_wdata;
   assign dm_we_out    = s_q.dm_we;
   assign dm_re_out    = s_q.dm_re;
   assign sreg_out     = s_q.sreg;

endmodule : cfe_core

//--- testbench/cfe_core_assertions.sv
// port-level property checker for the fetch/execute core
`timescale 1ns/1ps
module cfe_core_assertions
   import cfe_pkg::*;
#(
   parameter int RS_DEPTH = 4
)
(
   input wire logic        clk_in,
   input wire logic        rst_in,
   input wire logic [15:0] pm_addr_out,
   input wire logic [15:0] pm_data_in,
   input wire logic [15:0] dm_addr_out,
   input wire logic [7:0]  dm_wdata_out,
   input wire logic        dm_we_out,
   input wire logic        dm_re_out,
   input wire logic [7:0]  dm_rdata_in,
   input wire logic [7:0]  sreg_out
);
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (rst_in);

   // read-modify-write of a port bit
   sequence s_rmw;
      dm_re_out ##1 dm_we_out;
   endsequence

   a_rmw_same_addr: assert property (s_rmw |-> $stable(dm_addr_out))
      else $error("port bit write left the read address");
   a_rmw_io_region: assert property (s_rmw |-> dm_addr_out >= 16'h0020 && dm_addr_out < 16'h0060)
      else $error("port bit access outside the short io region");
   a_strobe_excl: assert property (!(dm_we_out && dm_re_out))
      else $error("read and write strobe together");
   a_read_pulse: assert property (dm_re_out |=> !dm_re_out)
      else $error("read strobe longer than one cycle");
   a_addr_moves: assert property ($changed(dm_addr_out) |-> dm_we_out || dm_re_out)
      else $error("data address moved without access");
   a_wdata_moves: assert property ($changed(dm_wdata_out) |-> dm_we_out)
      else $error("write data moved without store");
   a_reset_state: assert property ($fell(rst_in) |-> pm_addr_out == 16'h0000 && !dm_we_out && !dm_re_out
                                   && sreg_out == 8'h00)
      else $error("outputs not at reset values");
   a_fetch_start: assert property ($fell(rst_in) |=> pm_addr_out == 16'h0001 ##1 pm_addr_out == 16'h0002)
      else $error("fetch did not step after reset");
   a_sign_flag: assert property (sreg_out[CFE_F_S] == (sreg_out[CFE_F_N] ^ sreg_out[CFE_F_V]))
      else $error("sign flag not n xor v");
endmodule : cfe_core_assertions

bind cfe_core cfe_core_assertions #(.RS_DEPTH(RS_DEPTH)) i_chk (
   .clk_in(clk_in), .rst_in(rst_in), .pm_addr_out(pm_addr_out), .pm_data_in(pm_data_in),
   .dm_addr_out(dm_addr_out), .dm_wdata_out(dm_wdata_out), .dm_we_out(dm_we_out),
   .dm_re_out(dm_re_out), .dm_rdata_in(dm_rdata_in), .sreg_out(sreg_out));

//--- testbench/cfe_mem_model.sv
// program and data memory model on the two core buses
`timescale 1ns/1ps
module cfe_mem_model
(
   input  wire logic        clk_in,
   input  wire logic [15:0] pm_addr_in,
   output logic      [15:0] pm_data_out,
   input  wire logic [15:0] dm_addr_in,
   input  wire logic [7:0]  dm_wdata_in,
   input  wire logic        dm_we_in,
   input  wire logic        dm_re_in,
   output logic      [7:0]  dm_rdata_out
);
   logic [15:0] rom [0:511];
   logic [7:0]  ram [0:1023];

   assign pm_data_out = rom[pm_addr_in[8:0]];
   // undriven read line shows the inverted byte
   assign dm_rdata_out = dm_re_in ? ram[dm_addr_in[9:0]] : ~ram[dm_addr_in[9:0]];

   always @(posedge clk_in)
      if (dm_we_in)
         ram[dm_addr_in[9:0]] <= dm_wdata_in;
endmodule : cfe_mem_model

//--- testbench/cpu_fetch_execute_core_tb.sv
// self-checking bench of the fetch/execute core
`timescale 1ns/1ps
module cpu_fetch_execute_core_tb;
   import cfe_pkg::*;
   logic        clk_in;
   logic        rst_in;
   logic [15:0] pm_addr;
   logic [15:0] pm_data;
   logic [15:0] dm_addr;
   logic [7:0]  dm_wdata;
   logic        dm_we;
   logic        dm_re;
   logic [7:0]  dm_rdata;
   logic [7:0]  sreg;
   int          err_total = 0;
   int          samples_checked = 0;
   int          cyc = 0;

`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin err_total++; \
   $display("mismatch %s expected %h seen %h", nm, exp, got); end end

   cfe_core #(.RS_DEPTH(4)) i_dut (
      .clk_in(clk_in), .rst_in(rst_in), .pm_addr_out(pm_addr), .pm_data_in(pm_data),
      .dm_addr_out(dm_addr), .dm_wdata_out(dm_wdata), .dm_we_out(dm_we), .dm_re_out(dm_re),
      .dm_rdata_in(dm_rdata), .sreg_out(sreg));

   cfe_mem_model i_mem (
      .clk_in(clk_in), .pm_addr_in(pm_addr), .pm_data_out(pm_data), .dm_addr_in(dm_addr),
      .dm_wdata_in(dm_wdata), .dm_we_in(dm_we), .dm_re_in(dm_re), .dm_rdata_out(dm_rdata));

   initial
   begin
      clk_in = 1'b0;
      forever #50 clk_in = ~clk_in;
   end

   always @(posedge clk_in)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         err_total++;
         end_of_test();
      end
   end

   task automatic end_of_test();
      $display("checked %0d errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : end_of_test

   // load a program, hold reset five cycles, then run n cycles
   task automatic run(input int n, input logic [15:0] w [$]);
      @(negedge clk_in);
      rst_in = 1'b1;
      for (int i = 0; i < 1024; i++)
         i_mem.ram[i] = 8'h00;
      for (int i = 0; i < 512; i++)
         i_mem.rom[i] = (i < w.size()) ? w[i] : 16'h0000;
      repeat (5) @(negedge clk_in);
      rst_in = 1'b0;
      repeat (n) @(negedge clk_in);
   endtask : run

   task automatic t_stream();
      run(0, '{16'h0000});
      for (int i = 1; i <= 6; i++)
      begin
         @(negedge clk_in);
         `CHK("fetch address", 16'(i), pm_addr)
      end
   endtask : t_stream

   task automatic t_alu_ptr();
      run(60, '{16'he805, 16'he813, 16'h0f01, 16'h9300, 16'h0100, 16'h9310, 16'h0102, 16'h9130, 16'h0102,
                16'h9330, 16'h0101, 16'he0c0, 16'he0d2, 16'h8318, 16'he0a0, 16'he0b2, 16'h915c,
                16'h9350, 16'h0201, 16'hcfff});
      `CHK("sum", 8'h08, i_mem.ram[10'h100])
      `CHK("flags", 8'h19, sreg)
      `CHK("direct store", 8'h83, i_mem.ram[10'h102])
      `CHK("direct load", 8'h83, i_mem.ram[10'h101])
      `CHK("y store", 8'h83, i_mem.ram[10'h200])
      `CHK("x load", 8'h83, i_mem.ram[10'h201])
   endtask : t_alu_ptr

   task automatic t_table();
      run(30, '{16'he0f0, 16'he0e4, 16'h9144, 16'h9340, 16'h0103, 16'hcfff});
      `CHK("table byte", 8'h44, i_mem.ram[10'h103])
   endtask : t_table

   task automatic t_port_bits();
      run(40, '{16'hef00, 16'hbb00, 16'hbf0f, 16'h9884, 16'h9a80, 16'hcfff});
      `CHK("port byte", 8'he1, i_mem.ram[10'h030])
      `CHK("top port", 8'hf0, i_mem.ram[10'h05f])
      `CHK("extended io", 8'h00, i_mem.ram[10'h070])
   endtask : t_port_bits

   task automatic t_branch();
      run(30, '{16'he101, 16'hc001, 16'he202, 16'h9300, 16'h0100, 16'hcfff});
      `CHK("skipped word", 8'h11, i_mem.ram[10'h100])
   endtask : t_branch

   // long jump, port-bit skips, relative call, taken branch and return
   task automatic t_call_skip();
      run(50, '{16'he015, 16'h940c, 16'h0004, 16'hcfff, 16'hbb10, 16'h9b80, 16'he717, 16'h9981, 16'he818,
                16'hd003, 16'h9310, 16'h0104, 16'hcfff, 16'h5011, 16'hf409, 16'he717, 16'h9508});
      `CHK("port copy", 8'h05, i_mem.ram[10'h030])
      `CHK("call result", 8'h04, i_mem.ram[10'h104])
   endtask : t_call_skip

   initial
   begin
      rst_in = 1'b1;
      repeat (5) @(negedge clk_in);
      t_stream();
      t_alu_ptr();
      t_table();
      t_port_bits();
      t_branch();
      t_call_skip();
      end_of_test();
   end
endmodule : cpu_fetch_execute_core_tb
